// ### pkg/twm_map.svh
/*
  Register map, field positions, reset values and fixed codes of the
  two-wire bus master with address recognition.
  Assumes a 16-bit register port with word addresses on a 4-bit bus.
*/
// Contract
// R1: Slew limiting on both lines unless slew_limit_disable is set; needed for 1 MHz.
// R2: With accept_all_addr_enable set, every received address is accepted and answered.
// R3: Address byte of all zeros with direction zero is the fixed general call.
// R4: General call recognised only while general_call_enable, control bit 15, is one; the code also takes it with control bit 12 set or own address zero.
// R5: After a start, shift eight bits, compare with own address and general call.
// R6: On match copy shift to receive buffer, set full flag, event on ninth fall.
// R7: Software reads the receive buffer to tell own address from general call.
// R8: Master offers start, restart, transmit, stop, receive enable and acknowledge.
// R9: As master the block makes every clock pulse, start and stop.
// R10: Transfer ends by stop or restart; after restart the bus stays owned.
// R11: Master transmit sends address with direction zero, then bytes, sampling acknowledge.
// R12: Master receive sends address with direction one, then clocks data in.
// R13: Master receive takes eight bits per byte and drives acknowledge afterwards.
// R14: Any transmit register write is sent: data, address or second address byte.
// R15: Software writes the transmit register only while the master waits idle.
// R16: Transmit register write sets transmit-full flag and starts the bit-rate counter.
// R17: Each address or data bit goes onto SDA only after SCL went low.
// R18: Status bit 14 stays high while a master transmission runs.
// R19: Receive enable, control bit 11, starts reception; ignored unless idle.
// R20: Bit-rate counter loads reload value, counts to zero, stops; SCL toggles.
// R21: Software never programs the reload register with zero or one.
// R22: Counter reloads when SCL is sampled high, honouring clock stretching.
// R23: Lines are only pulled low; released for high; real levels sampled.
`ifndef TWM_MAP_SVH
`define TWM_MAP_SVH

`define TWM_ADDR_W    4
`define TWM_DATA_W    16

`define TWM_REG_CTRL  4'h0
`define TWM_REG_STAT  4'h1
`define TWM_REG_OWN   4'h2
`define TWM_REG_TX    4'h3
`define TWM_REG_RX    4'h4
`define TWM_REG_BRG   4'h5

`define TWM_CT_GENERAL_CALL_ENABLE   15
`define TWM_CT_ACC    12
`define TWM_CT_MASTER_RX_ENABLE   11
`define TWM_CT_SLWD   9
`define TWM_CT_ACKDT  5
`define TWM_CT_ACKEN  4
`define TWM_CT_PEN    2
`define TWM_CT_RSEN   1
`define TWM_CT_SEN    0
`define TWM_CT_KEEP   16'h9220

`define TWM_ST_ACK    15
`define TWM_ST_MASTER_TX_ACTIVE_FLAG 14
`define TWM_ST_GC     9
`define TWM_ST_HOLD   5
`define TWM_ST_IRQ    3
`define TWM_ST_RBF    1
`define TWM_ST_TBF    0

`define TWM_BRG_RST   16'h0028
`define TWM_GC_ADDR   8'h00
`define TWM_LAST_BIT  4'h7
`define TWM_ACK_BIT   4'h8
`define TWM_NINTH     4'h9

`endif

// ### pkg/twm_pkg.sv
/*
  Types of the two-wire bus master: master sequencer states and the
  packed state record of the controller.
  Assumes twm_map.svh is on the include path.
*/
`include "twm_map.svh"

package twm_pkg;

  typedef enum logic [2:0] {
    M_IDLE   = 3'b000,
    M_START  = 3'b001,
    M_RSTART = 3'b010,
    M_STOP   = 3'b011,
    M_TX     = 3'b100,
    M_RX     = 3'b101,
    M_ACK    = 3'b110
  } twm_mst_e;

  typedef struct packed {
    twm_mst_e                 ms;
    logic [1:0]               ph;
    logic [3:0]               bitn;
    logic [`TWM_DATA_W-1:0]   cnt, reload, ctrl, own, rdata;
    logic [7:0]               txsh, rxsh, rxbuf, svsh;
    logic [3:0]               svcnt;
    logic                     tx_buffer_full_flag, rx_buffer_full_flag, irq, ackstat, gcstat, hold;
    logic                     sda_oe, scl_oe, ld;
    logic                     scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
    logic                     sv_act, sv_ack, hit;
  } twm_state_s;

endpackage

// ### design/twm_master.sv
/*
  Two-wire bus master with own-address, general-call and accept-all
  recognition, register port, open-drain pin drivers and bit-rate counter.
  Assumes SCL_I/SDA_I are the real wired-AND line levels from the pads,
  asynchronous to REF_CLK, and a register master that never needs a wait.
*/
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "twm_map.svh"

module twm_master
  import twm_pkg::*;
(
  input  wire logic                   REF_CLK,
  input  wire logic                   SYS_RST,
  input  wire logic [`TWM_ADDR_W-1:0] REG_ADDR,
  input  wire logic [`TWM_DATA_W-1:0] REG_WDATA,
  input  wire logic                   REG_WR,
  input  wire logic                   REG_RD,
  output logic      [`TWM_DATA_W-1:0] REG_RDATA,
  input  wire logic                   SCL_I,
  output logic                        SCL_O,
  output logic                        SCL_OE,
  input  wire logic                   SDA_I,
  output logic                        SDA_O,
  output logic                        SDA_OE,
  output logic                        SLEW_LIMIT_EN,
  output logic                        MASTER_EVENT_FLAG
);

  // lines idle high: sync flops start high so reset makes no false edge
  localparam twm_state_s TWM_RST = '{ms: M_IDLE, reload: `TWM_BRG_RST,
                                     scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
                                     sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
                                     default: '0};

  twm_state_s               st_ff;
  twm_state_s               nxt_st;
  logic                     stretch;
  logic                     tick;
  logic                     scl_rise;
  logic                     scl_fall;
  logic                     bus_start;
  logic                     bus_stop;
  logic [`TWM_DATA_W-1:0]   stat_word;

  // address decision for a received first byte
  function automatic logic addr_hit(input logic [7:0]             sh,
                                    input logic [`TWM_DATA_W-1:0] ctl,
                                    input logic [`TWM_DATA_W-1:0] own);
    logic acc;
    logic gc;
    logic mine;
    acc  = ctl[`TWM_CT_ACC];                                   // R2
    gc   = ctl[`TWM_CT_GENERAL_CALL_ENABLE] && (sh == `TWM_GC_ADDR);          // R3 R4
    mine = (sh[7:1] == own[6:0]);                              // R5
    return acc || gc || mine;
  endfunction

  // a slave holding SCL low freezes the counter at its reload value
  assign stretch  = (st_ff.ms != M_IDLE) && !st_ff.scl_oe && !st_ff.scl_s;     // R22
  assign tick     = (st_ff.ms != M_IDLE) && !stretch && (st_ff.cnt == '0);     // R20

  // bus events seen on the synchronised line levels only
  assign scl_rise  = st_ff.scl_s && !st_ff.scl_p;
  assign scl_fall  = !st_ff.scl_s && st_ff.scl_p;
  assign bus_start = st_ff.scl_s && st_ff.scl_p && !st_ff.sda_s && st_ff.sda_p;
  assign bus_stop  = st_ff.scl_s && st_ff.scl_p && st_ff.sda_s && !st_ff.sda_p;

  // status word as software sees it
  always_comb begin
    stat_word                 = '0;
    stat_word[`TWM_ST_ACK]    = st_ff.ackstat;
    stat_word[`TWM_ST_MASTER_TX_ACTIVE_FLAG] = (st_ff.ms == M_TX);                            // R18
    stat_word[`TWM_ST_GC]     = st_ff.gcstat;
    stat_word[`TWM_ST_HOLD]   = st_ff.hold;
    stat_word[`TWM_ST_IRQ]    = st_ff.irq;
    stat_word[`TWM_ST_RBF]    = st_ff.rx_buffer_full_flag;
    stat_word[`TWM_ST_TBF]    = st_ff.tx_buffer_full_flag;
  end

  // whole next state; clears come before sets so a set in the same cycle wins
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.scl_m = SCL_I;                                                      // R23
    nxt_st.scl_s = st_ff.scl_m;
    nxt_st.scl_p = st_ff.scl_s;
    nxt_st.sda_m = SDA_I;
    nxt_st.sda_s = st_ff.sda_m;
    nxt_st.sda_p = st_ff.sda_s;
    nxt_st.hit   = 1'b0;
    nxt_st.rdata = '0;

    // register reads; data valid only in the following cycle
    if (REG_RD) begin
      case (REG_ADDR)
        `TWM_REG_CTRL: nxt_st.rdata = st_ff.ctrl;
        `TWM_REG_STAT: nxt_st.rdata = stat_word;
        `TWM_REG_OWN:  nxt_st.rdata = st_ff.own;
        `TWM_REG_TX:   nxt_st.rdata = {8'h00, st_ff.txsh};
        `TWM_REG_RX:   nxt_st.rdata = {8'h00, st_ff.rxbuf};                     // R7
        `TWM_REG_BRG:  nxt_st.rdata = st_ff.reload;
        default:       nxt_st.rdata = '0;
      endcase
      if (REG_ADDR == `TWM_REG_RX) begin
        nxt_st.rx_buffer_full_flag = 1'b0;
      end
    end

    // persistent register writes; command bits never stick
    if (REG_WR) begin
      case (REG_ADDR)
        `TWM_REG_CTRL: nxt_st.ctrl = REG_WDATA & `TWM_CT_KEEP;
        `TWM_REG_STAT: begin
          if (!REG_WDATA[`TWM_ST_IRQ]) begin
            nxt_st.irq = 1'b0;
          end
        end
        `TWM_REG_OWN:  nxt_st.own = REG_WDATA;
        `TWM_REG_BRG:  nxt_st.reload = REG_WDATA;                              // R21
        default: ;
      endcase
    end

    // bit-rate counter: runs only while an operation is active
    if (stretch || tick) begin
      nxt_st.cnt = st_ff.reload;                                               // R20 R22
    end else if (st_ff.ms != M_IDLE) begin
      nxt_st.cnt = st_ff.cnt - 16'h0001;
    end

    // master sequencer; every edge of SCL, and of SDA outside address recognition, is made here
    unique case (st_ff.ms)
      M_IDLE: begin
        // bus held with clock low: let go of data so the next bit starts clean
        if (st_ff.scl_oe) begin
          nxt_st.sda_oe = 1'b0;
        end
        nxt_st.ph   = 2'h0;
        nxt_st.bitn = 4'h0;
        nxt_st.ld   = 1'b1;
        nxt_st.cnt  = st_ff.reload;
        if (REG_WR && (REG_ADDR == `TWM_REG_CTRL)) begin                     // R8
          if (REG_WDATA[`TWM_CT_SEN]) begin
            nxt_st.ms = M_START;
          end else if (REG_WDATA[`TWM_CT_RSEN]) begin
            nxt_st.ms = M_RSTART;
          end else if (REG_WDATA[`TWM_CT_PEN]) begin
            nxt_st.ms = M_STOP;
          end else if (REG_WDATA[`TWM_CT_MASTER_RX_ENABLE]) begin
            nxt_st.ms = M_RX;                                                  // R19 R12
          end else if (REG_WDATA[`TWM_CT_ACKEN]) begin
            nxt_st.ms = M_ACK;
          end
        end else if (REG_WR && (REG_ADDR == `TWM_REG_TX)) begin
          // address, data or second address byte alike
          nxt_st.ms   = M_TX;                                                  // R14 R11
          nxt_st.txsh = REG_WDATA[7:0];
          nxt_st.tx_buffer_full_flag  = 1'b1;                                                  // R16
        end
      end

      M_START: begin
        if (tick) begin
          nxt_st.ph = st_ff.ph + 2'h1;
          if (st_ff.ph == 2'h0) begin
            nxt_st.sda_oe = 1'b1;                                              // R9
          end else begin
            nxt_st.scl_oe = 1'b1;
            nxt_st.hold   = 1'b1;
            nxt_st.ms     = M_IDLE;
          end
        end
      end

      M_RSTART: begin
        // bus ownership is kept throughout
        if (tick) begin
          nxt_st.ph = st_ff.ph + 2'h1;
          case (st_ff.ph)
            2'h0: nxt_st.sda_oe = 1'b0;
            2'h1: nxt_st.scl_oe = 1'b0;
            2'h2: nxt_st.sda_oe = 1'b1;
            default: begin
              nxt_st.scl_oe = 1'b1;                                            // R10
              nxt_st.ms     = M_IDLE;
            end
          endcase
        end
      end

      M_STOP: begin
        if (tick) begin
          nxt_st.ph = st_ff.ph + 2'h1;
          case (st_ff.ph)
            2'h0: nxt_st.sda_oe = 1'b1;
            2'h1: nxt_st.scl_oe = 1'b0;
            default: begin
              nxt_st.sda_oe = 1'b0;                                            // R10
              nxt_st.hold   = 1'b0;
              nxt_st.ms     = M_IDLE;
            end
          endcase
        end
      end

      M_TX, M_RX, M_ACK: begin
        // data changes one cycle after the clock flop went low, never with it
        if (st_ff.ld) begin
          nxt_st.ld = 1'b0;                                                    // R17
          if (st_ff.ms == M_TX) begin
            nxt_st.sda_oe = (st_ff.bitn != `TWM_ACK_BIT) && !st_ff.txsh[7];
          end else if (st_ff.ms == M_ACK) begin
            nxt_st.sda_oe = !st_ff.ctrl[`TWM_CT_ACKDT];                       // R13
          end else begin
            nxt_st.sda_oe = 1'b0;
          end
        end
        if (tick && (st_ff.ph == 2'h0)) begin
          nxt_st.scl_oe = 1'b0;                                                // R9
          nxt_st.ph     = 2'h1;
        end else if (tick) begin
          // end of the high phase: sample, then pull the clock low
          nxt_st.scl_oe = 1'b1;
          nxt_st.ph     = 2'h0;
          nxt_st.ld     = 1'b1;
          nxt_st.bitn   = st_ff.bitn + 4'h1;
          if (st_ff.ms == M_TX) begin
            if (st_ff.bitn == `TWM_ACK_BIT) begin
              nxt_st.ackstat = st_ff.sda_s;                                    // R11
              nxt_st.tx_buffer_full_flag     = 1'b0;
              nxt_st.irq     = 1'b1;
              nxt_st.ms      = M_IDLE;
            end else begin
              nxt_st.txsh = {st_ff.txsh[6:0], 1'b0};
            end
          end else if (st_ff.ms == M_RX) begin
            nxt_st.rxsh = {st_ff.rxsh[6:0], st_ff.sda_s};                     // R13
            if (st_ff.bitn == `TWM_LAST_BIT) begin
              nxt_st.rxbuf = {st_ff.rxsh[6:0], st_ff.sda_s};
              nxt_st.rx_buffer_full_flag   = 1'b1;
              nxt_st.irq   = 1'b1;
              nxt_st.ms    = M_IDLE;
            end
          end else begin
            nxt_st.irq = 1'b1;
            nxt_st.ms  = M_IDLE;
          end
        end
      end

      default: begin
        nxt_st.ms = M_IDLE;
      end
    endcase

    // address recognition; only while another master owns the bus
    if (st_ff.hold || (st_ff.ms != M_IDLE)) begin
      nxt_st.sv_act = 1'b0;
      nxt_st.sv_ack = 1'b0;
    end else if (bus_start) begin
      nxt_st.sv_act = 1'b1;                                                    // R5
      nxt_st.svcnt  = 4'h0;
    end else if (bus_stop) begin
      nxt_st.sv_act = 1'b0;
      nxt_st.sv_ack = 1'b0;
      nxt_st.sda_oe = 1'b0;
    end else if (st_ff.sv_act) begin
      if (scl_rise && (st_ff.svcnt < `TWM_ACK_BIT)) begin
        nxt_st.svsh  = {st_ff.svsh[6:0], st_ff.sda_s};                        // R5
        nxt_st.svcnt = st_ff.svcnt + 4'h1;
      end else if (scl_fall && (st_ff.svcnt == `TWM_ACK_BIT)) begin
        if (addr_hit(st_ff.svsh, st_ff.ctrl, st_ff.own)) begin
          nxt_st.hit    = 1'b1;
          nxt_st.rxbuf  = st_ff.svsh;                                          // R6
          nxt_st.rx_buffer_full_flag    = 1'b1;
          nxt_st.gcstat = (st_ff.svsh == `TWM_GC_ADDR);
          nxt_st.sv_ack = 1'b1;                                                // R2
          nxt_st.sda_oe = 1'b1;
          nxt_st.svcnt  = `TWM_NINTH;
        end else begin
          nxt_st.sv_act = 1'b0;
        end
      end else if (scl_fall && (st_ff.svcnt == `TWM_NINTH)) begin
        // event flag on the fall that closes the acknowledge bit
        nxt_st.irq    = 1'b1;                                                  // R6
        nxt_st.sv_ack = 1'b0;
        nxt_st.sda_oe = 1'b0;
        nxt_st.sv_act = 1'b0;
      end
    end
  end

  // single state register; reset loads a constant record
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_ff <= TWM_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // open-drain drivers: only ever pull low
  assign SCL_O             = 1'b0;                                             // R23
  assign SDA_O             = 1'b0;
  assign SCL_OE            = st_ff.scl_oe;
  assign SDA_OE            = st_ff.sda_oe;
  assign REG_RDATA         = st_ff.rdata;
  assign SLEW_LIMIT_EN     = !st_ff.ctrl[`TWM_CT_SLWD];                        // R1
  assign MASTER_EVENT_FLAG = st_ff.irq;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);

  property p_tx_start;
    (REG_WR && (REG_ADDR == `TWM_REG_TX) && (st_ff.ms == M_IDLE))
      |=> ((st_ff.ms == M_TX) && st_ff.tx_buffer_full_flag && (st_ff.cnt == st_ff.reload));
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx write did not start"); // R16

  property p_master_tx_active_flag;
    (REG_RD && (REG_ADDR == `TWM_REG_STAT) && (st_ff.ms == M_TX))
      |=> REG_RDATA[`TWM_ST_MASTER_TX_ACTIVE_FLAG];
  endproperty
  a_master_tx_active_flag: assert property (p_master_tx_active_flag) else $error("tx active bit low during tx"); // R18

  property p_rx_ignore;
    (REG_WR && (REG_ADDR == `TWM_REG_CTRL) && REG_WDATA[`TWM_CT_MASTER_RX_ENABLE]
      && (st_ff.ms inside {M_START, M_STOP, M_TX, M_ACK})) |=> (st_ff.ms != M_RX);
  endproperty
  a_rx_ignore: assert property (p_rx_ignore) else $error("rx enable taken while busy"); // R19

  property p_sda_low_clk;
    ((st_ff.ms inside {M_TX, M_RX, M_ACK}) && $changed(st_ff.sda_oe))
      |-> (st_ff.scl_oe && $past(st_ff.scl_oe));
  endproperty
  a_sda_low_clk: assert property (p_sda_low_clk) else $error("data moved with clock high"); // R17

  property p_stretch;
    (stretch && !REG_WR) |=> (st_ff.cnt == st_ff.reload);
  endproperty
  a_stretch: assert property (p_stretch) else $error("counter ran while clock held"); // R22

  property p_gc_gate;
    (st_ff.hit && (st_ff.rxbuf == `TWM_GC_ADDR) && !st_ff.ctrl[`TWM_CT_ACC]
      && (st_ff.own[6:0] != 7'h00)) |-> st_ff.ctrl[`TWM_CT_GENERAL_CALL_ENABLE];
  endproperty
  a_gc_gate: assert property (p_gc_gate) else $error("general call taken while disabled"); // R4

  property p_ninth_irq;
    (st_ff.sv_ack && st_ff.sv_act && scl_fall && !st_ff.hold && (st_ff.ms == M_IDLE))
      |=> (st_ff.irq && !st_ff.sda_oe);
  endproperty
  a_ninth_irq: assert property (p_ninth_irq) else $error("no event on ninth fall"); // R6

  property p_rs_hold;
    (st_ff.ms == M_RSTART) |=> st_ff.hold;
  endproperty
  a_rs_hold: assert property (p_rs_hold) else $error("bus released on restart"); // R10

  property p_rx_byte;
    ((st_ff.ms == M_RX) && tick && (st_ff.ph == 2'h1) && (st_ff.bitn == `TWM_LAST_BIT))
      |=> (st_ff.rx_buffer_full_flag && (st_ff.rxbuf == {$past(st_ff.rxsh[6:0]), $past(st_ff.sda_s)})
           && (st_ff.ms == M_IDLE));
  endproperty
  a_rx_byte: assert property (p_rx_byte) else $error("received byte not stored"); // R13

endmodule
`default_nettype wire

// ### dv/twm_slave_model.sv
/*
  Behavioural two-wire bus slave: acknowledges its own address, keeps the
  last written byte, returns a fixed byte on reads, can stretch the clock.
  Assumes scl and sda are the resolved wired-AND line levels.
*/
`timescale 1ns/1ps
`default_nettype none

module twm_slave_model #(
  parameter logic [6:0] ADDR    = 7'h50,
  parameter int         HOLD_NS = 600
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] rd_byte,
  input  wire logic       stretch,
  output logic            sda_oe,
  output logic            scl_oe,
  output logic [7:0]      last_wr,
  output logic            ack_lvl
);
  logic [7:0] sh;
  int         nb;
  logic       act, first, sel, rd;

  initial begin
    {sda_oe, scl_oe, act, first, sel, rd} = '0;
    sh      = '0;
    last_wr = '0;
    ack_lvl = 1'b1;
    nb      = 0;
  end

  // start or restart: data falls while the clock is high
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      act   = 1'b1;
      first = 1'b1;
      sel   = 1'b0;
      nb    = 0;
    end
  end

  // stop ends the frame and frees the data line
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      act    = 1'b0;
      sda_oe = 1'b0;
    end
  end

  // bits taken on the rising clock, ninth bit is the acknowledge
  always @(posedge scl) begin
    if (act) begin
      sh = {sh[6:0], sda};
      nb = nb + 1;
      if (nb == 9) begin
        ack_lvl = sda;
      end
    end
  end

  // drive only in the low phase; stretch mid-byte when asked
  always @(negedge scl) begin
    if (act && nb == 8) begin
      if (first) begin
        sel = (sh[7:1] == ADDR);
        rd  = sh[0];
      end else if (sel && !rd) begin
        last_wr = sh;
      end
      sda_oe = sel && (first || !rd);
    end else if (act) begin
      if (nb == 9) begin
        nb    = 0;
        first = 1'b0;
      end
      sda_oe = sel && rd && !first && !rd_byte[7 - nb];
      if (nb == 4 && stretch) begin
        scl_oe = 1'b1;
        #(HOLD_NS);
        scl_oe = 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// ### dv/tb_top.sv
/*
  Self-checking bench of the two-wire master: register port, master write
  and read through a slave model, address recognition from a bench master.
  Assumes twm_pkg is compiled and twm_map.svh is on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "twm_map.svh"

module tb_top;
  localparam logic [6:0] SL_ADDR = 7'h50;
  localparam int         RELOAD  = 2;

  typedef struct packed {logic [3:0] a; logic [15:0] d, e; logic s;} twm_row_s;
  typedef struct packed {logic [15:0] c; logic [7:0] b; logic m, g;} twm_arow_s;

  logic        ref_clk, sys_rst, reg_wr, reg_rd, stretch, ex_scl, ex_sda, in_byte;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv;
  logic        scl_oe, sda_oe, scl_o, sda_o, slew_en, ev_flag;
  logic        sl_scl_oe, sl_sda_oe, ack_lvl, ack, fh, fl;
  logic [7:0]  last_wr;
  int          n_mismatch, n_tests;
  realtime     t_rise;
  // open-drain lines with pull-ups: any party pulling wins
  wire         scl_w = !(scl_oe | sl_scl_oe | ex_scl);
  wire         sda_w = !(sda_oe | sl_sda_oe | ex_sda);

  twm_row_s rows [6] = '{
    '{`TWM_REG_CTRL, 16'h0200, 16'h0200, 1'b0},
    '{`TWM_REG_CTRL, 16'h9020, 16'h9020, 1'b1},
    '{`TWM_REG_CTRL, 16'h0000, 16'h0000, 1'b1},
    '{`TWM_REG_OWN, 16'h002A, 16'h002A, 1'b1},
    '{`TWM_REG_BRG, RELOAD, RELOAD, 1'b1},
    '{4'hF, 16'h1234, 16'h0000, 1'b1}};
  twm_arow_s arows [6] = '{
    '{16'h8000, 8'h00, 1'b1, 1'b1}, '{16'h0000, 8'h00, 1'b0, 1'b0},
    '{16'h8000, 8'h01, 1'b0, 1'b0}, '{16'h1000, 8'h5A, 1'b1, 1'b0},
    '{16'h0000, 8'h54, 1'b1, 1'b0}, '{16'h0000, 8'h56, 1'b0, 1'b0}};

  twm_master dut_u (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda_w), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .SLEW_LIMIT_EN(slew_en), .MASTER_EVENT_FLAG(ev_flag));

  twm_slave_model #(.ADDR(SL_ADDR)) sl_u (.scl(scl_w), .sda(sda_w), .rd_byte(8'hA6),
    .stretch(stretch), .sda_oe(sl_sda_oe), .scl_oe(sl_scl_oe), .last_wr(last_wr),
    .ack_lvl(ack_lvl));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = !ref_clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // bounded wait for the end-of-operation flag, then clear it
  task automatic wait_ev(input int lim);
    int i = 0;
    while (ev_flag !== 1'b1 && i < lim) begin
      @(posedge ref_clk);
      i++;
    end
    chk("event flag", 16'h1, {15'h0, ev_flag});
    if (ev_flag !== 1'b1) conclude();
    wr(`TWM_REG_STAT, 16'h0000);
  endtask

  task automatic op(input logic [15:0] d, input int lim);
    wr(`TWM_REG_CTRL, d);
    wait_ev(lim);
  endtask

  // start, restart and stop raise no flag: wait for their final line pattern
  task automatic op_oe(input logic [15:0] d, input logic [1:0] oe, input int lim);
    int i = 0;
    wr(`TWM_REG_CTRL, d);
    while ({scl_oe, sda_oe} !== oe && i < lim) begin
      @(posedge ref_clk);
      i++;
    end
    chk("line drive after command", {14'h0, oe}, {14'h0, scl_oe, sda_oe});
    if ({scl_oe, sda_oe} !== oe) conclude();
  endtask

  task automatic tx(input logic [7:0] b, input logic master_rx_enable);
    int rel = 0;
    in_byte = 1'b1;
    wr(`TWM_REG_TX, {8'h00, b});
    rd(`TWM_REG_STAT, rv);
    chk("tx busy status", 16'h4001, rv & 16'h4001);
    if (master_rx_enable) wr(`TWM_REG_CTRL, 16'h0800);
    wait_ev(400);
    rd(`TWM_REG_STAT, rv);
    chk("ack and idle status", 16'h0000, rv & 16'hC001);
    // a refused receive enable must not start clocking
    repeat (master_rx_enable ? 40 : 0) begin
      @(posedge ref_clk);
      rel += !scl_oe;
    end
    chk("clock after refused enable", 16'h0, rel[15:0]);
    in_byte = 1'b0;
  endtask

  // bench acting as an outside master at a 160 ns bit period
  task automatic ex_frame(input logic [7:0] b, output logic ak, output logic f_hi,
                          output logic f_lo);
    #1 ex_sda = 1'b1;
    #40 ex_scl = 1'b1;
    for (int i = 7; i >= -1; i--) begin
      #40 ex_sda = (i >= 0) ? !b[i] : 1'b0;
      #40 ex_scl = 1'b0;
      #40 ak = sda_w;
      f_hi = ev_flag;
      #40 ex_scl = 1'b1;
    end
    ex_sda = 1'b1;
    #40 f_lo = ev_flag;
    ex_scl = 1'b0;
    #40 ex_sda = 1'b0;
    #80;
  endtask

  // data may only change while the clock line is low
  always @(sda_oe) begin
    if (in_byte && scl_w === 1'b1) chk("data edge with clock high", 16'h0, 16'h1);
  end

  // a stretched low phase must not shorten the following high phase
  always @(posedge scl_w) t_rise = $realtime;
  always @(negedge scl_w) begin
    if (in_byte && $realtime - t_rise < (RELOAD + 1) * 4.0) begin
      chk("clock high time", 16'h0, 16'h1);
    end
  end

  initial begin
    {sys_rst, reg_wr, reg_rd, stretch, ex_scl, ex_sda, in_byte} = 7'b1000000;
    reg_addr   = '0;
    reg_wdata  = '0;
    n_mismatch = 0;
    n_tests    = 0;
    t_rise     = 0;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(`TWM_REG_BRG, rv);
    chk("reload after reset", `TWM_BRG_RST, rv);
    chk("slew after reset", 16'h1, {15'h0, slew_en});
    // register rows, last one unmapped
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rv);
      chk("register readback", rows[i].e, rv);
      chk("slew enable", {15'h0, rows[i].s}, {15'h0, slew_en});
    end
    // master write: start, address, data, receive enable refused meanwhile
    op_oe(16'h0001, 2'b11, 200);
    chk("clock held after start", 16'h1, {15'h0, scl_oe});
    tx({SL_ADDR, 1'b0}, 1'b0);
    tx(8'hC3, 1'b1);
    chk("slave got byte", 16'h00C3, {8'h0, last_wr});
    // restart, read one byte under clock stretching, acknowledge it
    op_oe(16'h0002, 2'b11, 200);
    chk("bus kept after restart", 16'h1, {15'h0, scl_oe});
    tx({SL_ADDR, 1'b1}, 1'b0);
    in_byte = 1'b1;
    stretch = 1'b1;
    op(16'h0800, 800);
    stretch = 1'b0;
    rd(`TWM_REG_RX, rv);
    chk("received byte", 16'h00A6, rv);
    op(16'h0010, 400);
    chk("ack level", 16'h0, {15'h0, ack_lvl});
    // second byte, closed by a not-acknowledge before the stop
    op(16'h0800, 400);
    rd(`TWM_REG_RX, rv);
    chk("second byte", 16'h00A6, rv);
    op(16'h0030, 400);
    chk("nack level", 16'h1, {15'h0, ack_lvl});
    in_byte = 1'b0;
    op_oe(16'h0004, 2'b00, 200);
    chk("lines after stop", 16'h0, {14'h0, scl_oe, sda_oe});
    chk("drive levels", 16'h0, {14'h0, scl_o, sda_o});
    // address recognition rows
    foreach (arows[i]) begin
      wr(`TWM_REG_CTRL, arows[i].c);
      ex_frame(arows[i].b, ack, fh, fl);
      chk("recognition ack", {15'h0, !arows[i].m}, {15'h0, ack});
      chk("flag before ninth fall", 16'h0, {15'h0, fh});
      chk("flag after ninth fall", {15'h0, arows[i].m}, {15'h0, fl});
      if (arows[i].m) begin
        rd(`TWM_REG_STAT, rv);
        chk("match status", {6'h0, arows[i].g, 9'h00A}, rv & 16'h020A);
        rd(`TWM_REG_RX, rv);
        chk("received address", {8'h0, arows[i].b}, rv);
        wr(`TWM_REG_STAT, 16'h0000);
      end
    end
    conclude();
  end
endmodule

`default_nettype wire
